// *** hdl/cac_pkg.sv ***
// Shared constants for the counter array compare, pulse-width and watchdog block
// Overview of operation
// - High-speed output mode inverts the module pin on each counter/compare match.
// - High-speed output needs toggle_on_match, match_enable and comparator_enable set.
// - Writing compare_low while comparator_enable is set clears comparator_enable.
// - Writing compare_high sets the module's comparator_enable bit.
// - comparator_enable stays directly writable and readable in the mode register.
// - All pulse-width outputs share one frequency from the shared counter.
// - Each module's duty is set by its own compare_low, which its compare_high reloads on each low-byte wrap.
// - PWM output low while counter low byte below compare_low, else high.
// - On counter low byte wrap FF to 00, compare_high reloads compare_low.
// - PWM mode needs pulse_width_enable and comparator_enable both set.
// - Only module 4 can raise the watchdog reset.
// - Module 4 keeps all other modes when the watchdog is unused.
// - Watchdog asserts internal reset when counter matches 16-bit compare value.
// - Watchdog reset never drives the external reset pin.
// - watchdog_enable clear disables watchdog reset; set re-enables it.
// - Each module holds a 16-bit compare in high and low bytes, reset zero.
// - A match sets module_event_flag; irq raised when flag and irq enable set.
package cac_pkg;
    localparam int NUM_MODULES = 5;
    localparam int WDT_MODULE  = 4;
    localparam int PRESCALE_DEFAULT = 1;
    localparam int WDT_PULSE_DEFAULT = 4;
    // Mode register fields
    localparam int MODE_W         = 7;
    localparam int MODE_IRQ_EN    = 0;
    localparam int MODE_PWM       = 1;
    localparam int MODE_TOGGLE    = 2;
    localparam int MODE_MATCH     = 3;
    localparam int MODE_COMP_EN   = 6;
    // Control register fields
    localparam int CTRL_RUN       = 0;
    localparam int CTRL_WDT_EN    = 1;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CNT_LO   = 8'he9;
    localparam logic [7:0] IDX_CNT_HI   = 8'hf9;
    localparam logic [7:0] IDX_CMP_LO0  = 8'hea;
    localparam logic [7:0] IDX_CMP_HI0  = 8'hfa;
    localparam logic [7:0] IDX_MODE0    = 8'hd0;
    localparam logic [7:0] IDX_CTRL     = 8'hc0;
    localparam logic [7:0] IDX_FLAGS    = 8'hc1;
    // Values after reset
    localparam logic [7:0]        BYTE_RESET = 8'h00;
    localparam logic [MODE_W-1:0] MODE_RESET = 7'h00;
    localparam logic [1:0]        CTRL_RESET = 2'h0;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hdl/cac_timebase.sv ***
// Shared free-running counter with prescaler
`timescale 1ns/1ns
module cac_timebase import cac_pkg::*; #(
    parameter int PRESCALE = PRESCALE_DEFAULT
) (
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_run,
    input  wire logic        i_load_lo,
    input  wire logic        i_load_hi,
    input  wire logic [7:0]  i_wdata,
    output logic      [15:0] o_count,
    output logic      [15:0] o_count_nxt,
    output logic             o_step
);
    logic [7:0] pre_r;
    logic       tick;

    // A load in the same cycle suppresses the step, so no stray match or wrap fires
    assign tick        = i_run && (pre_r == 8'(PRESCALE - 1));
    assign o_step      = tick && !i_load_lo && !i_load_hi;
    assign o_count_nxt = o_count + 16'h0001;

    always_ff @(posedge i_clock) begin
        if (i_reset || !i_run || tick) begin
            pre_r <= 8'h00;
        end else begin
            pre_r <= pre_r + 8'h01;
        end
    end

    // Software load wins over an increment in the same cycle
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_count <= {BYTE_RESET, BYTE_RESET};
        end else if (i_load_lo) begin
            o_count[7:0] <= i_wdata;
        end else if (i_load_hi) begin
            o_count[15:8] <= i_wdata;
        end else if (o_step) begin
            o_count <= o_count_nxt;
        end
    end
endmodule // cac_timebase

// *** hdl/cac_channel_out.sv ***
// One compare module: match detection and output pin
`timescale 1ns/1ns
module cac_channel_out import cac_pkg::*; #(
    parameter bit IS_WDT = 1'b0
) (
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic [MODE_W-1:0] i_mode,
    input  wire logic [7:0]        i_cmp_lo,
    input  wire logic [7:0]        i_cmp_hi,
    input  wire logic              i_step,
    input  wire logic [15:0]       i_count,
    input  wire logic [15:0]       i_count_nxt,
    input  wire logic              i_wdt_en,
    output logic                   o_pin,
    output logic                   o_match,
    output logic                   o_wdt_hit
);
    logic comp_en;
    logic cmp_mode;
    logic pwm_mode;

    assign comp_en  = i_mode[MODE_COMP_EN];
    assign cmp_mode = comp_en && i_mode[MODE_MATCH] && !i_mode[MODE_PWM];
    assign pwm_mode = comp_en && i_mode[MODE_PWM];
    // Compared against the value the counter is stepping to: once per pass
    assign o_match  = i_step && cmp_mode && (i_count_nxt == {i_cmp_hi, i_cmp_lo});
    assign o_wdt_hit = IS_WDT && i_wdt_en && o_match;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_pin <= 1'b0;
        end else if (pwm_mode) begin
            o_pin <= (i_count[7:0] >= i_cmp_lo);
        end else if (o_match && i_mode[MODE_TOGGLE]) begin
            o_pin <= ~o_pin;
        end
    end
endmodule // cac_channel_out

// *** hdl/cac_top.sv ***
// Compare, pulse-width and watchdog unit with AXI4-Lite register access
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module cac_top import cac_pkg::*; #(
    parameter int ADDR_W    = 12,
    parameter int PRESCALE  = PRESCALE_DEFAULT,
    parameter int WDT_PULSE = WDT_PULSE_DEFAULT
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RESET,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] I_AWADDR,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [ADDR_W-1:0] I_ARADDR,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    // Block outputs
    output logic [NUM_MODULES-1:0] O_MODULE_IO_PIN,
    output logic                   O_EVENT_IRQ,
    output logic                   O_WDT_RESET
);
    // ==========================================================
    // Address decoding helpers
    function automatic logic [NUM_MODULES-1:0] slot_hit(input logic [7:0] idx,
                                                        input logic [7:0] base);
        logic [NUM_MODULES-1:0] hit;
        hit = '0;
        for (int k = 0; k < NUM_MODULES; k++) begin
            hit[k] = (idx == base + 8'(k));
        end
        return hit;
    endfunction

    function automatic logic in_range(input logic [ADDR_W-1:0] addr);
        return (addr[ADDR_W-1:10] == '0);
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        return (|slot_hit(idx, IDX_MODE0)) || (|slot_hit(idx, IDX_CMP_LO0))
            || (|slot_hit(idx, IDX_CMP_HI0)) || (idx == IDX_CNT_LO)
            || (idx == IDX_CNT_HI) || (idx == IDX_CTRL) || (idx == IDX_FLAGS);
    endfunction

    // ==========================================================
    // Declarations
    logic [ADDR_W-1:0]      aw_addr_r;
    logic                   aw_full_r;
    logic [7:0]             w_data_r;
    logic [3:0]             w_strb_r;
    logic                   w_full_r;
    logic                   bvalid_r;
    logic [1:0]             bresp_r;
    logic                   rvalid_r;
    logic [1:0]             rresp_r;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;

    logic                   do_wr;
    logic                   wr_ok;
    logic                   wr_en;
    logic [7:0]             wr_idx;
    logic [7:0]             rd_idx;
    logic [NUM_MODULES-1:0] wr_mode_sel;
    logic [NUM_MODULES-1:0] wr_lo_sel;
    logic [NUM_MODULES-1:0] wr_hi_sel;
    logic [NUM_MODULES-1:0] rd_mode_sel;
    logic [NUM_MODULES-1:0] rd_lo_sel;
    logic [NUM_MODULES-1:0] rd_hi_sel;

    logic [MODE_W-1:0]      mode_r   [NUM_MODULES];
    logic [7:0]             cmp_lo_r [NUM_MODULES];
    logic [7:0]             cmp_hi_r [NUM_MODULES];
    logic [1:0]             ctrl_r;
    logic [NUM_MODULES-1:0] flag_r;
    logic [NUM_MODULES-1:0] flag_clr;
    logic [NUM_MODULES-1:0] irq_en;

    logic [15:0]            count;
    logic [15:0]            count_nxt;
    logic                   step;
    logic                   lo_wrap;
    logic [NUM_MODULES-1:0] match;
    logic [NUM_MODULES-1:0] wdt_hit;
    logic [NUM_MODULES-1:0] pin;
    logic [7:0]             wdt_cnt_r;
    logic                   irq_r;

    // ==========================================================
    // AXI4-Lite write channel
    // Address and data are held independently and taken in either order
    assign O_AWREADY = !aw_full_r;
    assign O_WREADY  = !w_full_r;
    assign O_BVALID  = bvalid_r;
    assign O_BRESP   = bresp_r;

    assign do_wr  = aw_full_r && w_full_r && !bvalid_r;
    assign wr_idx = aw_addr_r[9:2];
    assign wr_ok  = in_range(aw_addr_r) && is_mapped(wr_idx);
    // Registers are one byte wide: only lane 0 carries data
    assign wr_en  = do_wr && wr_ok && w_strb_r[0];

    assign wr_mode_sel = wr_en ? slot_hit(wr_idx, IDX_MODE0)   : '0;
    assign wr_lo_sel   = wr_en ? slot_hit(wr_idx, IDX_CMP_LO0) : '0;
    assign wr_hi_sel   = wr_en ? slot_hit(wr_idx, IDX_CMP_HI0) : '0;

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (I_AWVALID && !aw_full_r) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= I_AWADDR;
        end else if (do_wr) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            w_full_r <= 1'b0;
            w_data_r <= BYTE_RESET;
            w_strb_r <= 4'h0;
        end else if (I_WVALID && !w_full_r) begin
            w_full_r <= 1'b1;
            w_data_r <= I_WDATA[7:0];
            w_strb_r <= I_WSTRB;
        end else if (do_wr) begin
            w_full_r <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (I_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign O_ARREADY = !rvalid_r;
    assign O_RVALID  = rvalid_r;
    assign O_RDATA   = rdata_r;
    assign O_RRESP   = rresp_r;
    assign rd_idx    = I_ARADDR[9:2];

    assign rd_mode_sel = slot_hit(rd_idx, IDX_MODE0);
    assign rd_lo_sel   = slot_hit(rd_idx, IDX_CMP_LO0);
    assign rd_hi_sel   = slot_hit(rd_idx, IDX_CMP_HI0);

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        for (int n = 0; n < NUM_MODULES; n++) begin
            if (rd_mode_sel[n]) begin
                rdata_nxt[MODE_W-1:0] = mode_r[n];
            end
            if (rd_lo_sel[n]) begin
                rdata_nxt[7:0] = cmp_lo_r[n];
            end
            if (rd_hi_sel[n]) begin
                rdata_nxt[7:0] = cmp_hi_r[n];
            end
        end
        if (rd_idx == IDX_CNT_LO) begin
            rdata_nxt[7:0] = count[7:0];
        end
        if (rd_idx == IDX_CNT_HI) begin
            rdata_nxt[7:0] = count[15:8];
        end
        if (rd_idx == IDX_CTRL) begin
            rdata_nxt[1:0] = ctrl_r;
        end
        if (rd_idx == IDX_FLAGS) begin
            rdata_nxt[NUM_MODULES-1:0] = flag_r;
        end
        if (!in_range(I_ARADDR)) begin
            rdata_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (I_ARVALID && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdata_nxt;
            rresp_r  <= (in_range(I_ARADDR) && is_mapped(rd_idx)) ? RESP_OKAY : RESP_SLVERR;
        end else if (I_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Control register: counter run and watchdog enable
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_en && wr_idx == IDX_CTRL) begin
            ctrl_r <= w_data_r[1:0];
        end
    end

    // ==========================================================
    // Shared counter, the one time base for every module
    cac_timebase #(
        .PRESCALE    (PRESCALE)
    ) u_timebase (
        .i_clock     (I_CLOCK),
        .i_reset     (I_RESET),
        .i_run       (ctrl_r[CTRL_RUN]),
        .i_load_lo   (wr_en && wr_idx == IDX_CNT_LO),
        .i_load_hi   (wr_en && wr_idx == IDX_CNT_HI),
        .i_wdata     (w_data_r),
        .o_count     (count),
        .o_count_nxt (count_nxt),
        .o_step      (step)
    );

    assign lo_wrap = step && (count[7:0] == 8'hff);

    // ==========================================================
    // Per-module registers and output logic
    generate
        for (genvar n = 0; n < NUM_MODULES; n++) begin : g_mod
            // Mode: direct write, else side effects of compare byte writes
            always_ff @(posedge I_CLOCK) begin
                if (I_RESET) begin
                    mode_r[n] <= MODE_RESET;
                end else if (wr_mode_sel[n]) begin
                    mode_r[n] <= w_data_r[MODE_W-1:0];
                end else if (wr_lo_sel[n]) begin
                    mode_r[n][MODE_COMP_EN] <= 1'b0;
                end else if (wr_hi_sel[n]) begin
                    mode_r[n][MODE_COMP_EN] <= 1'b1;
                end
            end

            // A software write wins over the wrap reload
            always_ff @(posedge I_CLOCK) begin
                if (I_RESET) begin
                    cmp_lo_r[n] <= BYTE_RESET;
                end else if (wr_lo_sel[n]) begin
                    cmp_lo_r[n] <= w_data_r;
                end else if (lo_wrap && mode_r[n][MODE_COMP_EN] && mode_r[n][MODE_PWM]) begin
                    cmp_lo_r[n] <= cmp_hi_r[n];
                end
            end

            always_ff @(posedge I_CLOCK) begin
                if (I_RESET) begin
                    cmp_hi_r[n] <= BYTE_RESET;
                end else if (wr_hi_sel[n]) begin
                    cmp_hi_r[n] <= w_data_r;
                end
            end

            cac_channel_out #(
                .IS_WDT      (n == WDT_MODULE)
            ) u_chan (
                .i_clock     (I_CLOCK),
                .i_reset     (I_RESET),
                .i_mode      (mode_r[n]),
                .i_cmp_lo    (cmp_lo_r[n]),
                .i_cmp_hi    (cmp_hi_r[n]),
                .i_step      (step),
                .i_count     (count),
                .i_count_nxt (count_nxt),
                .i_wdt_en    (ctrl_r[CTRL_WDT_EN]),
                .o_pin       (pin[n]),
                .o_match     (match[n]),
                .o_wdt_hit   (wdt_hit[n])
            );

            assign irq_en[n]   = mode_r[n][MODE_IRQ_EN];
            assign flag_clr[n] = wr_en && (wr_idx == IDX_FLAGS) && w_data_r[n];
        end
    endgenerate

    assign O_MODULE_IO_PIN = pin;

    // ==========================================================
    // Event flags: write one to clear; a match in the same cycle wins
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            flag_r <= '0;
        end else begin
            flag_r <= (flag_r & ~flag_clr) | match;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(flag_r & irq_en);
        end
    end

    assign O_EVENT_IRQ = irq_r;

    // ==========================================================
    // Watchdog reset request
    // Internal only: this block has no path to the external reset pin
    always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
            wdt_cnt_r <= 8'h00;
        end else if (|wdt_hit) begin
            wdt_cnt_r <= 8'(WDT_PULSE);
        end else if (wdt_cnt_r != 8'h00) begin
            wdt_cnt_r <= wdt_cnt_r - 8'h01;
        end
    end

    assign O_WDT_RESET = (wdt_cnt_r != 8'h00);

endmodule // cac_top

// *** bench/cac_pin_load.sv ***
// Load model on the module output pins: high time and rising edges per pin
`timescale 1ns/1ns
module cac_pin_load import cac_pkg::*; (
    input  wire logic                   i_clock,
    input  wire logic                   i_clear,
    input  wire logic [NUM_MODULES-1:0] i_pin,
    output logic      [15:0]            o_high [NUM_MODULES],
    output logic      [15:0]            o_rises [NUM_MODULES]
);
    logic [NUM_MODULES-1:0] last_r;
    // Any window of whole periods gives the same counts, whatever its phase
    always_ff @(posedge i_clock) begin
        last_r <= i_pin;
        for (int n = 0; n < NUM_MODULES; n++) begin
            o_high[n]  <= i_clear ? 16'h0000 : o_high[n] + 16'(i_pin[n]);
            o_rises[n] <= i_clear ? 16'h0000 : o_rises[n] + 16'(i_pin[n] & ~last_r[n]);
        end
    end
endmodule // cac_pin_load

// *** bench/cac_properties.sv ***
// Port-level checks of the compare unit
`timescale 1ns/1ns
module cac_properties import cac_pkg::*; #(
    parameter int WDT_PULSE = WDT_PULSE_DEFAULT
) (
    input wire logic                   I_CLOCK,
    input wire logic                   I_RESET,
    input wire logic                   I_AWVALID,
    input wire logic                   O_AWREADY,
    input wire logic                   I_WVALID,
    input wire logic                   O_WREADY,
    input wire logic                   O_BVALID,
    input wire logic                   I_ARVALID,
    input wire logic                   O_ARREADY,
    input wire logic                   O_RVALID,
    input wire logic [31:0]            O_RDATA,
    input wire logic                   I_RREADY,
    input wire logic [NUM_MODULES-1:0] O_MODULE_IO_PIN,
    input wire logic                   O_WDT_RESET
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RESET);
    int hi_n;
    // Length of the current reset request
    always_ff @(posedge I_CLOCK) hi_n <= (I_RESET || !O_WDT_RESET) ? 0 : hi_n + 1;
    AST_WDT_LEN: assert property ($fell(O_WDT_RESET) |-> hi_n == WDT_PULSE)
        else $error("watchdog request length wrong");
    AST_WDT_MAX: assert property (hi_n <= WDT_PULSE)
        else $error("watchdog request too long");
    AST_RESET_QUIET: assert property ($fell(I_RESET) |->
        O_MODULE_IO_PIN == '0 && !O_WDT_RESET && !O_BVALID && !O_RVALID)
        else $error("outputs not idle after reset");
    AST_WR_LAT: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
        |-> ##2 O_BVALID) else $error("write response late");
    AST_AW_HELD: assert property (I_AWVALID && O_AWREADY |=> !O_AWREADY)
        else $error("address taken twice");
    AST_RD_LAT: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
        else $error("read data late");
    AST_AR_BLOCK: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read taken while data pending");
    AST_R_DONE: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read data repeated");
    AST_RD_UPPER: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
        else $error("upper read bits set");
endmodule // cac_properties

// *** bench/tb.sv ***
// Self-checking bench of the compare, pulse-width and watchdog unit
`timescale 1ns/1ns
module tb import cac_pkg::*;;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   clear = 1'b1;
    logic [11:0]            awaddr = '0, araddr = '0;
    logic [31:0]            wdata = '0, rdata, rd_d;
    logic                   awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic                   awready, wready, bvalid, arready, rvalid, irq, wdt;
    logic [1:0]             bresp, rresp, rd_r, wr_r;
    logic [NUM_MODULES-1:0] pins;
    logic [15:0]            high [NUM_MODULES], rises [NUM_MODULES];
    logic                   wdt_last = 1'b0;
    int                     num_errors = 0, compares = 0, cyc = 0, wdt_rises = 0;

    cac_top #(.PRESCALE(1), .WDT_PULSE(4)) cac_top_inst (
        .I_CLOCK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hf), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(1'b1),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(1'b1), .O_MODULE_IO_PIN(pins),
        .O_EVENT_IRQ(irq), .O_WDT_RESET(wdt));
    cac_pin_load cac_pin_load_inst (.i_clock(clk), .i_clear(clear), .i_pin(pins),
        .o_high(high), .o_rises(rises));

    always #4 clk = ~clk;
    // Cycle ceiling well above the roughly 1700 cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        wdt_last <= wdt;
        if (wdt && !wdt_last) wdt_rises <= wdt_rises + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ==========================================
    // Bus tasks
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a && w)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        wr_r = bresp;
    endtask
    task automatic rd(input logic [7:0] idx);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd_d = rdata;
        rd_r = rresp;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
        rd(idx);
        chk(rd_d, e);
    endtask
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        clear <= 1'b0;
        for (int n = 0; n < NUM_MODULES; n++) begin
            rchk(IDX_CMP_LO0 + 8'(n), 32'h0);
            rchk(IDX_CMP_HI0 + 8'(n), 32'h0);
            rchk(IDX_MODE0 + 8'(n), 32'h0);
        end
        wr(8'h00, 8'h5a);
        chk(wr_r, RESP_SLVERR);
        rchk(8'h00, 32'h0);
        chk(rd_r, RESP_SLVERR);
        $display("test reset done");
        wr(IDX_MODE0, 8'h4c);
        rchk(IDX_MODE0, 32'h4c);
        wr(IDX_CMP_LO0, 8'h10);
        rchk(IDX_MODE0, 32'h0c);
        wr(IDX_CMP_HI0, 8'h00);
        rchk(IDX_MODE0, 32'h4c);
        wr(IDX_MODE0, 8'h0c);
        rchk(IDX_MODE0, 32'h0c);
        $display("test comparator enable done");
        wr(IDX_MODE0, 8'h4d);
        wr(IDX_CMP_LO0 + 8'h01, 8'h10);
        wr(IDX_CMP_HI0 + 8'h01, 8'h00);
        wr(IDX_MODE0 + 8'h01, 8'h48);
        wr(IDX_CTRL, 8'h01);
        while (pins[0] !== 1'b1) @(posedge clk);
        repeat (40) @(posedge clk);
        chk(pins, 5'h01);
        chk(rises[0], 16'h1);
        chk(irq, 1'b1);
        rchk(IDX_FLAGS, 32'h03);
        wr(IDX_FLAGS, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        $display("test toggle output done");
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CNT_LO, 8'h00);
        wr(IDX_CNT_HI, 8'h00);
        wr(IDX_CMP_LO0 + 8'h02, 8'h40);
        wr(IDX_CMP_HI0 + 8'h02, 8'hc0);
        wr(IDX_MODE0 + 8'h02, 8'h42);
        wr(IDX_CMP_LO0 + 8'h03, 8'h10);
        wr(IDX_MODE0 + 8'h03, 8'h02);
        wr(IDX_CMP_LO0 + 8'h04, 8'h80);
        wr(IDX_CMP_HI0 + 8'h04, 8'h80);
        wr(IDX_MODE0 + 8'h04, 8'h42);
        wr(IDX_CTRL, 8'h01);
        while (pins[2] !== 1'b1) @(posedge clk);
        while (pins[2] !== 1'b0) @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (256) @(posedge clk);
        #1;
        chk(high[2], 16'd64);
        chk(high[3], 16'd0);
        chk(high[4], 16'd128);
        chk(rises[2], 16'd1);
        chk(rises[4], 16'd1);
        @(posedge clk);
        rchk(IDX_CMP_LO0 + 8'h02, 32'hc0);
        $display("test pulse width done");
        for (int p = 0; p < 3; p++) begin
            wr(IDX_CTRL, 8'h00);
            wr(IDX_CNT_LO, 8'h00);
            wr(IDX_CNT_HI, 8'h00);
            if (p == 0) begin
                wr(IDX_CMP_LO0 + 8'h04, 8'h00);
                wr(IDX_CMP_HI0 + 8'h04, 8'h01);
                wr(IDX_MODE0 + 8'h04, 8'h48);
            end
            wr(IDX_CTRL, p == 0 ? 8'h01 : 8'h03);
            repeat (200) @(posedge clk);
            chk(wdt_rises, p / 2);
            // Last pass: software moves the compare value ahead of the timer
            if (p == 2) begin
                wr(IDX_CMP_LO0 + 8'h04, 8'h00);
                wr(IDX_CMP_HI0 + 8'h04, 8'h02);
            end
            repeat (100) @(posedge clk);
            chk(wdt_rises, (p + 1) / 2);
        end
        $display("test watchdog done");
        end_of_test();
    end
endmodule // tb

bind cac_top cac_properties #(.WDT_PULSE(WDT_PULSE)) cac_properties_inst (
    .I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA), .I_RREADY(I_RREADY),
    .O_MODULE_IO_PIN(O_MODULE_IO_PIN), .O_WDT_RESET(O_WDT_RESET));
